// ### src/wmt_top.sv
// wmt_top: two-unit 32-bit input capture timer with apb registers
//
// Contract
// - two units, four capture channels each
// - counters count from reset release onward
// - counters have no stop or enable
// - measure event stores counter into capture
// - control bit 15 picks half clock or bus1
// - unit0 bits 8-11 pick pin or bus
// - unit1 bits 8-11 pick pin or bus
// - capture events may raise input interrupt
// - counter wraps silently, no overflow interrupt
// - counter read as one 32-bit word
// - capture words read-only, writes ignored
`timescale 1ns/1ps
module wmt_top #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wmt_pkg::wmt_apb_req_s apb_req,
    output wmt_pkg::wmt_apb_rsp_s apb_rsp,
    // measure sources
    input wmt_pkg::wmt_pins_s pins,
    input wire logic [3:0] event_bus,
    input wire logic clock_bus1,
    // interrupt
    output logic input_event_interrupt
);
    import wmt_pkg::*;

    localparam int NSYNC = WMT_CAPS + 1;

    generate
        if (CNT_W < 2 || CNT_W > WMT_DATA_W) begin : g_bad_width
            $error("wmt_top: CNT_W must lie between 2 and 32");
        end
        // capture select bits must address exactly the capture store
        if (WMT_CAP_MSB - WMT_CAP_LSB + 1 != WMT_CAP_AW || WMT_CAPS > (1 << WMT_CAP_AW)) begin : g_bad_cap_map
            $error("wmt_top: capture address field does not match capture count");
        end
        // status and mask must fit one bus word
        if (WMT_CAPS > WMT_DATA_W) begin : g_bad_status
            $error("wmt_top: too many capture channels for one status word");
        end
    endgenerate

    function automatic wmt_reg_e decode(input logic [31:0] a);
        logic [31:0] cap_base;
        cap_base = wmt_byte_addr(WMT_CAP_BASE_IDX);
        if (a == wmt_byte_addr(WMT_UNIT0_CTRL_IDX)) begin
            return WMT_REG_CTRL0;
        end else if (a == wmt_byte_addr(WMT_UNIT1_CTRL_IDX)) begin
            return WMT_REG_CTRL1;
        end else if (a == wmt_byte_addr(WMT_CNT0_IDX)) begin
            return WMT_REG_CNT0;
        end else if (a == wmt_byte_addr(WMT_CNT1_IDX)) begin
            return WMT_REG_CNT1;
        end else if (a == wmt_byte_addr(WMT_STATUS_IDX)) begin
            return WMT_REG_STAT;
        end else if (a == wmt_byte_addr(WMT_MASK_IDX)) begin
            return WMT_REG_MASK;
        end else if (a[31:WMT_CAP_MSB+1] == cap_base[31:WMT_CAP_MSB+1] && a[WMT_CAP_LSB-1:0] == 2'b00) begin
            return WMT_REG_CAP;
        end
        return WMT_REG_NONE;
    endfunction : decode

    // ---------------- input synchronisers ----------------
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg, level_reg;
    logic [NSYNC-1:0] sync1_next, sync2_next, sync3_next, level_next;
    logic [NSYNC-1:0] pin_rise;
    logic [3:0] bus_prev_reg, bus_prev_next;
    logic [3:0] bus_rise;

    assign raw_in = {clock_bus1, pins};

    always_comb begin
        sync1_next = raw_in;
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        // a level is accepted only once stages two and three agree
        level_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (level_reg & (sync2_reg ^ sync3_reg));
        pin_rise = sync2_reg & sync3_reg & ~level_reg;
        bus_prev_next = event_bus;
        bus_rise = event_bus & ~bus_prev_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            level_reg <= '0;
            bus_prev_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            level_reg <= level_next;
            bus_prev_reg <= bus_prev_next;
        end
    end

    // ---------------- apb front end ----------------
    logic apb_setup, apb_access, wr_fire, rd_done;
    wmt_reg_e dec;
    logic rd_stage_reg, rd_stage_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] rd_mux;
    logic [31:0] cap_rd;

    logic [WMT_UNITS-1:0][31:0] ctrl_reg, ctrl_next;
    logic [WMT_UNITS-1:0][CNT_W-1:0] cnt_reg, cnt_next;
    logic [WMT_CAPS-1:0] status_reg, status_next;
    logic [WMT_CAPS-1:0] mask_reg, mask_next;
    logic irq_reg, irq_next;
    logic [WMT_CAPS-1:0] status_clr;

    assign apb_setup = apb_req.psel & ~apb_req.penable;
    assign apb_access = apb_req.psel & apb_req.penable;
    assign dec = decode(apb_req.paddr);
    // writes complete at once; reads wait one cycle for the registered capture word
    assign wr_fire = apb_access & apb_req.pwrite;
    assign rd_done = apb_access & ~apb_req.pwrite & rd_stage_reg;

    always_comb begin
        rd_mux = '0;
        case (dec)
            WMT_REG_CTRL0: rd_mux = ctrl_reg[0];
            WMT_REG_CTRL1: rd_mux = ctrl_reg[1];
            WMT_REG_CNT0: rd_mux = 32'(cnt_reg[0]);
            WMT_REG_CNT1: rd_mux = 32'(cnt_reg[1]);
            WMT_REG_CAP: rd_mux = cap_rd;
            WMT_REG_STAT: rd_mux = 32'(status_reg);
            WMT_REG_MASK: rd_mux = 32'(mask_reg);
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        rd_stage_next = rd_stage_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (apb_setup) begin
            pslverr_next = (dec == WMT_REG_NONE);
            rd_stage_next = 1'b0;
        end
        if (apb_access && !apb_req.pwrite && !rd_stage_reg) begin
            prdata_next = rd_mux;
            rd_stage_next = 1'b1;
        end
        if (rd_done) begin
            rd_stage_next = 1'b0;
        end
    end

    always_comb begin
        apb_rsp.prdata = prdata_reg;
        apb_rsp.pready = apb_req.penable & (apb_req.pwrite | rd_stage_reg);
        apb_rsp.pslverr = pslverr_reg;
    end

    // ---------------- control registers ----------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_fire && dec == WMT_REG_CTRL0) begin
            ctrl_next[0] = wmt_merge(ctrl_reg[0], apb_req.pwdata, apb_req.pstrb) & WMT_CTRL_WMASK;
        end
        if (wr_fire && dec == WMT_REG_CTRL1) begin
            ctrl_next[1] = wmt_merge(ctrl_reg[1], apb_req.pwdata, apb_req.pstrb) & WMT_CTRL_WMASK;
        end
    end

    // ---------------- counter clocks and counters ----------------
    logic half_reg, half_next;
    logic cb1_tick;
    logic [WMT_UNITS-1:0] unit_tick;
    logic [WMT_UNITS-1:0] cnt_wr;

    assign half_next = ~half_reg;
    // clock bus 1 passes the pin sampler, so it must run no faster than a quarter of pclk
    assign cb1_tick = pin_rise[NSYNC-1];
    // a write under clock bus 1 is taken as is; software must keep off it
    assign cnt_wr[0] = wr_fire && dec == WMT_REG_CNT0;
    assign cnt_wr[1] = wr_fire && dec == WMT_REG_CNT1;

    always_comb begin
        for (int u = 0; u < WMT_UNITS; u++) begin
            unit_tick[u] = ctrl_reg[u][WMT_CTRL_CLKSEL_BIT] ? cb1_tick : half_reg;
        end
    end

    // no enable term anywhere: only reset, or a still clock bus 1 while selected, holds the counters
    always_comb begin
        cnt_next = cnt_reg;
        for (int u = 0; u < WMT_UNITS; u++) begin
            if (cnt_wr[u]) begin
                cnt_next[u] = CNT_W'(wmt_merge(32'(cnt_reg[u]), apb_req.pwdata, apb_req.pstrb));
            end else if (unit_tick[u]) begin
                // plain wrap at all-ones, nothing is flagged
                cnt_next[u] = cnt_reg[u] + 1'b1;
            end
        end
    end

    // ---------------- capture channels ----------------
    logic [WMT_CAPS-1:0] cap_ev;
    logic [WMT_CAPS-1:0][WMT_DATA_W-1:0] cap_wdata;

    genvar k;
    generate
        for (k = 0; k < WMT_CAPS; k++) begin : g_chan
            // unit k/4, channel k%4: pin when the select bit is 0, event bus line when 1
            assign cap_ev[k] = ctrl_reg[k / WMT_CH][WMT_CTRL_SRC_LSB + k % WMT_CH] ?
                               bus_rise[k % WMT_CH] : pin_rise[k];
            assign cap_wdata[k] = 32'(cnt_reg[k / WMT_CH]);
        end
    endgenerate

    // capture words are written only by events, never by the bus
    wmt_capture_mem #(
        .W(WMT_DATA_W),
        .DEPTH(WMT_CAPS),
        .AW(WMT_CAP_AW)
    ) u_caps (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(cap_ev),
        .wr_data(cap_wdata),
        .rd_addr(apb_req.paddr[WMT_CAP_MSB:WMT_CAP_LSB]),
        .rd_data(cap_rd)
    );

    // ---------------- interrupt status and mask ----------------
    always_comb begin
        status_clr = '0;
        // clear only what the read returned, so a bit set meanwhile survives
        if (rd_done && dec == WMT_REG_STAT) begin
            status_clr = prdata_reg[WMT_CAPS-1:0];
        end
        status_next = (status_reg & ~status_clr) | cap_ev;
        mask_next = mask_reg;
        if (wr_fire && dec == WMT_REG_MASK) begin
            mask_next = WMT_CAPS'(wmt_merge(32'(mask_reg), apb_req.pwdata, apb_req.pstrb));
        end
        irq_next = |(status_next & mask_next);
    end

    // registered, so the line cannot glitch while status and mask settle
    assign input_event_interrupt = irq_reg;

    // bus front end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_stage_reg <= 1'b0;
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else begin
            rd_stage_reg <= rd_stage_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // control words come up selecting the pins and the half clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= {WMT_UNITS{WMT_CTRL_RESET}};
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // divider and counters; only reset, or a still clock bus 1 while it is selected, holds them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            half_reg <= half_next;
            cnt_reg <= cnt_next;
        end
    end

    // sticky status, mask and the registered interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= WMT_STATUS_RESET;
            mask_reg <= WMT_MASK_RESET;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

endmodule : wmt_top

// ### include/wmt_pkg.sv
// wmt_pkg: shared constants, types and helpers of the wide measure timer
package wmt_pkg;

    localparam int WMT_UNITS = 2;
    localparam int WMT_CH = 4;
    localparam int WMT_CAPS = WMT_UNITS * WMT_CH;
    localparam int WMT_DATA_W = 32;
    localparam int WMT_CAP_AW = 3;

    // register indices; the byte address on the bus is four times the index
    localparam logic [31:0] WMT_UNIT1_CTRL_IDX = 32'h0080_0feb;
    localparam logic [31:0] WMT_UNIT0_CTRL_IDX = 32'h0080_0fea;
    localparam logic [31:0] WMT_CNT0_IDX = 32'h0080_0fc0;
    localparam logic [31:0] WMT_CNT1_IDX = 32'h0080_0fc1;
    localparam logic [31:0] WMT_CAP_BASE_IDX = 32'h0080_0fc8;
    localparam logic [31:0] WMT_STATUS_IDX = 32'h0080_0fd0;
    localparam logic [31:0] WMT_MASK_IDX = 32'h0080_0fd1;

    // address bits that pick one of the eight capture words
    localparam int WMT_CAP_LSB = 2;
    localparam int WMT_CAP_MSB = 4;

    // control word fields
    localparam int WMT_CTRL_SRC_LSB = 8;
    localparam int WMT_CTRL_CLKSEL_BIT = 15;
    localparam logic [31:0] WMT_CTRL_WMASK = 32'h0000_8f00;
    localparam logic [31:0] WMT_CTRL_RESET = 32'h0000_0000;

    localparam logic [WMT_CAPS-1:0] WMT_STATUS_RESET = 8'h00;
    localparam logic [WMT_CAPS-1:0] WMT_MASK_RESET = 8'h00;
    localparam logic [31:0] WMT_CAP_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        WMT_REG_NONE = 3'b000,
        WMT_REG_CTRL0 = 3'b001,
        WMT_REG_CTRL1 = 3'b010,
        WMT_REG_CNT0 = 3'b011,
        WMT_REG_CNT1 = 3'b100,
        WMT_REG_CAP = 3'b101,
        WMT_REG_STAT = 3'b110,
        WMT_REG_MASK = 3'b111
    } wmt_reg_e;

    // bit k = unit * 4 + channel
    typedef struct packed {
        logic unit1_ch3_pin;
        logic unit1_ch2_pin;
        logic unit1_ch1_pin;
        logic unit1_ch0_pin;
        logic unit0_ch3_pin;
        logic unit0_ch2_pin;
        logic unit0_ch1_pin;
        logic unit0_ch0_pin;
    } wmt_pins_s;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } wmt_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wmt_apb_rsp_s;

    function automatic logic [31:0] wmt_byte_addr(input logic [31:0] idx);
        return {idx[29:0], 2'b00};
    endfunction : wmt_byte_addr

    function automatic logic [31:0] wmt_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : wmt_merge

endpackage : wmt_pkg

// ### src/wmt_capture_mem.sv
// wmt_capture_mem: capture word store, one write port per word, registered read
`timescale 1ns/1ps
module wmt_capture_mem #(
    parameter int W = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // per-word capture writes
    input wire logic [DEPTH-1:0] wr_en,
    input wire logic [DEPTH-1:0][W-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    import wmt_pkg::*;

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW) || W < 1 || W > 32) begin : g_bad
            $error("wmt_capture_mem: unsupported W, DEPTH or AW");
        end
    endgenerate

    logic [DEPTH-1:0][W-1:0] mem_reg;
    logic [DEPTH-1:0][W-1:0] mem_next;
    logic [W-1:0] rd_data_next;

    // every channel may capture in the same cycle, so each word has its own port
    always_comb begin
        mem_next = mem_reg;
        for (int i = 0; i < DEPTH; i++) begin
            if (wr_en[i]) begin
                mem_next[i] = wr_data[i];
            end
        end
        rd_data_next = '0;
        if (int'(rd_addr) < DEPTH) begin
            rd_data_next = mem_reg[rd_addr];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_reg <= {DEPTH{WMT_CAP_RESET[W-1:0]}};
            rd_data <= '0;
        end else begin
            mem_reg <= mem_next;
            rd_data <= rd_data_next;
        end
    end

endmodule : wmt_capture_mem

// ### bench/wmt_top_monitor.sv
// wmt_top_monitor: port-level assertions of the wide measure timer
`timescale 1ns/1ps
module wmt_top_monitor #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wmt_pkg::wmt_apb_req_s apb_req,
    input wmt_pkg::wmt_apb_rsp_s apb_rsp,
    // sources and interrupt
    input wmt_pkg::wmt_pins_s pins,
    input wire logic [3:0] event_bus,
    input wire logic clock_bus1,
    input wire logic input_event_interrupt
);
    import wmt_pkg::*;
    logic [31:0] ix;
    logic done;
    logic rd_done;
    logic [7:0] quiet_reg, quiet_next, clr_reg, clr_next;
    assign ix = {2'b00, apb_req.paddr[31:2]};
    assign done = apb_req.psel & apb_req.penable & apb_rsp.pready;
    assign rd_done = done & ~apb_req.pwrite;
    // cycles since any pin or event bus line was high, and since any completed status or mask access, read or write
    always_comb begin
        quiet_next = (quiet_reg == 8'hff) ? quiet_reg : quiet_reg + 8'h01;
        clr_next = (clr_reg == 8'hff) ? clr_reg : clr_reg + 8'h01;
        if ((|pins) || (|event_bus)) begin
            quiet_next = 8'h00;
        end
        if (done && (ix == WMT_STATUS_IDX || ix == WMT_MASK_IDX)) begin
            clr_next = 8'h00;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_reg <= 8'hff;
            clr_reg <= 8'hff;
        end else begin
            quiet_reg <= quiet_next;
            clr_reg <= clr_next;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_setup;
        apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    endsequence
    sequence s_access;
        apb_req.psel && apb_req.penable;
    endsequence
    a_read_one_wait: assert property (s_rd_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
        else $error("read not answered after exactly one wait");
    a_write_no_wait: assert property (s_access ##0 apb_req.pwrite |-> apb_rsp.pready)
        else $error("write access held waiting");
    a_reset_quiet: assert property ($rose(presetn) |-> !input_event_interrupt)
        else $error("interrupt high right after reset");
    a_irq_has_cause: assert property ($rose(input_event_interrupt) |-> quiet_reg < 8'd12 || clr_reg < 8'd4)
        else $error("interrupt rose without a measure event");
    a_irq_stands: assert property ($fell(input_event_interrupt) |-> clr_reg < 8'd4)
        else $error("interrupt dropped without status read or mask write");
    a_ctrl_zero_bits: assert property (rd_done && (ix == WMT_UNIT0_CTRL_IDX || ix == WMT_UNIT1_CTRL_IDX)
        |-> (apb_rsp.prdata & 32'hffff_70ff) == 32'h0000_0000)
        else $error("control read shows bits outside select fields");
    a_cap_read_ok: assert property (rd_done && ix[31:3] == WMT_CAP_BASE_IDX[31:3] |-> !apb_rsp.pslverr)
        else $error("capture read flagged as error");
    a_cnt_read_ok: assert property (rd_done && ix[31:1] == WMT_CNT0_IDX[31:1] |-> !apb_rsp.pslverr)
        else $error("counter read flagged as error");
endmodule : wmt_top_monitor
bind wmt_top wmt_top_monitor #(.CNT_W(CNT_W)) u_wmt_mon (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pins(pins), .event_bus(event_bus), .clock_bus1(clock_bus1),
    .input_event_interrupt(input_event_interrupt));

// ### bench/wmt_source_model.sv
// wmt_source_model: external pins, event bus and clock bus 1 of the far side
`timescale 1ns/1ps
module wmt_source_model (
    // clock
    input wire logic pclk,
    // sources
    output wmt_pkg::wmt_pins_s pins,
    output logic [3:0] event_bus,
    output logic clock_bus1
);
    import wmt_pkg::*;
    logic run_cb1 = 1'b0;
    initial begin
        pins = '0;
        event_bus = 4'h0;
        clock_bus1 = 1'b0;
    end
    // held four cycles so the pin sampler sees it high twice
    task automatic pin_pulse(input int k);
        pins[k] <= 1'b1;
        repeat (4) @(posedge pclk);
        pins[k] <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask : pin_pulse
    task automatic bus_pulse(input int n);
        event_bus[n] <= 1'b1;
        @(posedge pclk);
        event_bus[n] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : bus_pulse
    // clock bus 1 stands still unless enabled, period six pclk
    always begin
        repeat (3) @(posedge pclk);
        if (run_cb1) begin
            clock_bus1 <= ~clock_bus1;
        end
    end
endmodule : wmt_source_model

// ### bench/wmt_top_tb.sv
// wmt_top_tb: self-checking bench of the wide measure timer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module wmt_top_tb;
    import wmt_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wmt_apb_req_s apb_req = '0;
    wmt_apb_rsp_s apb_rsp;
    wmt_pins_s pins;
    logic [3:0] event_bus;
    logic clock_bus1;
    logic irq;
    logic err;
    logic [31:0] rd, v0, v1, c;
    logic [3:0] s0, s1;
    logic [3:0] strb = 4'hf;
    logic [31:0] ridx [4] = '{WMT_UNIT0_CTRL_IDX, WMT_UNIT1_CTRL_IDX, WMT_STATUS_IDX, WMT_MASK_IDX};
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int t, k, off;
    always #4 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    wmt_top #(.CNT_W(32)) DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins),
        .event_bus(event_bus), .clock_bus1(clock_bus1), .input_event_interrupt(irq));
    wmt_source_model src (.pclk(pclk), .pins(pins), .event_bus(event_bus), .clock_bus1(clock_bus1));
    function automatic logic near(input logic [31:0] d, input int e);
        return (d + 32'd1 >= e) && (d <= e + 1);
    endfunction : near
    // one full apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] ix, input logic [31:0] d, output logic [31:0] q);
        apb_req.paddr <= {ix[29:0], 2'b00};
        apb_req.pwrite <= w;
        apb_req.pwdata <= d;
        apb_req.pstrb <= strb;
        apb_req.psel <= 1'b1;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic final_report();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        final_report();
    end
    initial begin
        void'($urandom(32'hc761b278));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // idle through reset, first half-clock count two edges after release
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v0);
        `CHK(near(v0, 1), 1'b1)
        foreach (ridx[i]) begin
            apb(1'b0, ridx[i], 32'h0, rd);
            `CHK(rd, 32'h0000_0000)
        end
        apb(1'b1, WMT_UNIT1_CTRL_IDX, 32'hffff_ffff, rd);
        apb(1'b0, WMT_UNIT1_CTRL_IDX, 32'h0, rd);
        `CHK(rd, 32'h0000_8f00)
        apb(1'b1, WMT_UNIT1_CTRL_IDX, 32'h0, rd);
        // half clock rate: one count per two pclk, never stopping
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v0);
        t = cyc;
        repeat (100 + $urandom_range(20)) @(posedge pclk);
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v1);
        `CHK(near(v1 - v0, (cyc - t) / 2), 1'b1)
        apb(1'b1, WMT_MASK_IDX, 32'h0000_00ff, rd);
        // byte lane 0 off: the mask byte must survive a write of zero
        strb = 4'he;
        apb(1'b1, WMT_MASK_IDX, 32'h0, rd);
        strb = 4'hf;
        apb(1'b0, WMT_MASK_IDX, 32'h0, rd);
        `CHK(rd, 32'h0000_00ff)
        apb(1'b1, WMT_CNT0_IDX, 32'hffff_fff0, rd);
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v0);
        `CHK(v0 >= 32'hffff_fff0 && v0 < 32'hffff_fff6, 1'b1)
        repeat (60) @(posedge pclk);
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v1);
        `CHK(v1 < 32'h0000_0040, 1'b1)
        `CHK(irq, 1'b0)
        c = $urandom & 32'h7fff_ffff;
        apb(1'b1, WMT_CNT1_IDX, c, rd);
        apb(1'b0, WMT_CNT1_IDX, 32'h0, v0);
        `CHK(near(v0 - c, 2), 1'b1)
        // every channel from its pin, random starting channel
        off = $urandom_range(7);
        for (int i = 0; i < WMT_CAPS; i++) begin
            k = (i + off) % WMT_CAPS;
            apb(1'b0, WMT_CNT0_IDX + (k >> 2), 32'h0, v0);
            src.pin_pulse(k);
            apb(1'b0, WMT_CNT0_IDX + (k >> 2), 32'h0, v1);
            `CHK(irq, 1'b1)
            apb(1'b0, WMT_STATUS_IDX, 32'h0, rd);
            `CHK(rd, 32'h1 << k)
            apb(1'b0, WMT_CAP_BASE_IDX + k, 32'h0, c);
            `CHK(c > v0 && c < v1, 1'b1)
            `CHK(irq, 1'b0)
            apb(1'b1, WMT_CAP_BASE_IDX + k, $urandom, rd);
            apb(1'b0, WMT_CAP_BASE_IDX + k, 32'h0, rd);
            `CHK(rd, c)
        end
        // masked event stays silent until unmasked
        apb(1'b1, WMT_MASK_IDX, 32'h0, rd);
        src.pin_pulse(5);
        `CHK(irq, 1'b0)
        apb(1'b1, WMT_MASK_IDX, 32'h0000_0020, rd);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b0, WMT_STATUS_IDX, 32'h0, rd);
        // source select: random pattern, then its inverse
        s0 = 4'($urandom);
        s1 = 4'($urandom);
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, WMT_UNIT0_CTRL_IDX, {16'h0, 4'h0, s0, 8'h00}, rd);
            apb(1'b1, WMT_UNIT1_CTRL_IDX, {16'h0, 4'h0, s1, 8'h00}, rd);
            for (int n = 0; n < 4; n++) begin
                src.bus_pulse(n);
                apb(1'b0, WMT_STATUS_IDX, 32'h0, rd);
                `CHK(rd, (32'(s0[n]) << n) | (32'(s1[n]) << (n + 4)))
                src.pin_pulse(n);
                src.pin_pulse(n + 4);
                apb(1'b0, WMT_STATUS_IDX, 32'h0, rd);
                `CHK(rd, (32'(!s0[n]) << n) | (32'(!s1[n]) << (n + 4)))
            end
            s0 = ~s0;
            s1 = ~s1;
        end
        // clock bus 1 selected: still while it stands, counts its rising edges once running
        apb(1'b1, WMT_UNIT0_CTRL_IDX, 32'h0000_8000, rd);
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v0);
        repeat (40) @(posedge pclk);
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v1);
        `CHK(v1, v0)
        src.run_cb1 = 1'b1;
        t = cyc;
        repeat (120) @(posedge pclk);
        apb(1'b0, WMT_CNT0_IDX, 32'h0, v0);
        `CHK(near(v0 - v1, (cyc - t) / 6), 1'b1)
        apb(1'b0, WMT_MASK_IDX + 32'h1, 32'h0, rd);
        `CHK({err, rd}, 33'h1_0000_0000)
        final_report();
    end
endmodule : wmt_top_tb
